//--- core/adc_readout_pkg.sv
// Purpose: shared constants and state types of the serial readout block
// Assumes: system clock of 20 MHz, crystal timebase of 32.768 kHz
// Notes:   counts derived from times are computed here once
package adc_readout_pkg;

	localparam int WORD_BITS      = 24;
	localparam int CLK_HZ         = 20000000;
	localparam int CRYSTAL_HZ     = 32768;
	// the converter clock is this multiple of the crystal
	localparam int PLL_MULT       = 128;
	localparam int CONV_CLK_HZ    = CRYSTAL_HZ * PLL_MULT;
	// system cycles per half crystal period, rounded down
	localparam int HALF_DIV       = CLK_HZ / (2 * CRYSTAL_HZ);
	// crystal periods per output word
	localparam int FILT_DEC_A     = 69;
	localparam int FILT_DEC_B     = 8;
	localparam int FILT_DEC_C     = 3;
	localparam int CONV_TICKS     = FILT_DEC_A * FILT_DEC_B * FILT_DEC_C;
	// settling is two output periods
	localparam int SETTLE_CONV    = 2;
	// crystal periods spent waiting for lock after power-up
	localparam int LOCK_TICKS     = 64;
	localparam int FIFO_DEPTH     = 2;

	localparam logic [23:0] CODE_ZERO = 24'h800000;
	localparam logic [23:0] CODE_MAX  = 24'hffffff;
	localparam logic [23:0] CODE_MIN  = 24'h000000;
	// gain 16 is a left shift by four
	localparam int GAIN_HI_SHIFT  = 4;

	typedef enum logic [1:0]
	{
		PW_STANDBY = 2'b00,
		PW_LOCK    = 2'b01,
		PW_RUN     = 2'b11
	} power_state_t;

	typedef enum logic [1:0]
	{
		RD_IDLE  = 2'b00,
		RD_READY = 2'b01,
		RD_SHIFT = 2'b11,
		RD_DONE  = 2'b10
	} read_state_t;

endpackage

//--- core/pin_sync.sv
// Purpose: two-flop synchroniser for pins from outside the clock domain
// Assumes: each bit is sampled on its own; words are not coherent
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] pin,
	output logic      [WIDTH-1:0] level
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			logic meta_q;
			logic level_q;
			always_ff @(posedge clk)
			begin
				if (rst)
				begin
					meta_q  <= 1'b1;
					level_q <= 1'b1;
				end
				else
				begin
					meta_q  <= pin[i];
					level_q <= meta_q;
				end
			end
			assign level[i] = level_q;
		end
	endgenerate

endmodule

//--- core/result_fifo.sv
// Purpose: small result buffer between converter and serial shifter
// Assumes: depth is a power of two
// Notes:   flush empties it at once; full refuses writes
`timescale 1ns/1ps
module result_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 2
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             flush,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_q;
	logic [AW-1:0]    rd_ptr_q;
	logic [AW:0]      count_q;
	logic             push;
	logic             pop;

	assign in_ready  = (count_q != (AW+1)'(DEPTH));
	assign out_valid = (count_q != '0);
	assign out_data  = mem[rd_ptr_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_ready && out_valid;

	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_ptr_q] <= in_data;
	end

	always_ff @(posedge clk)
	begin
		if (rst || flush)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_q <= wr_ptr_q + 1'b1;
			if (pop)
				rd_ptr_q <= rd_ptr_q + 1'b1;
			if (push && !pop)
				count_q <= count_q + 1'b1;
			else if (pop && !push)
				count_q <= count_q - 1'b1;
		end
	end

endmodule

//--- core/adc_serial_readout.sv
// Purpose: conversion control and serial readout of a two-channel converter
// Assumes: analog inputs arrive as signed codes scaled to 2^23 at gain one
// Notes:   crystal and converter rates are enables derived from clk
`timescale 1ns/1ps
module adc_serial_readout
	import adc_readout_pkg::*;
#(
	parameter int HALF_CYCLES = HALF_DIV,
	parameter int CONV_PERIOD = CONV_TICKS,
	parameter int LOCK_PERIOD = LOCK_TICKS
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        cs_n,
	input  wire logic        mode_slave,
	input  wire logic        input_pair_select,
	input  wire logic        range_wide,
	input  wire logic        sclk_in,
	input  wire logic [23:0] input_pair1_pos,
	input  wire logic [23:0] input_pair2_pos,
	output logic             sclk_out,
	output logic             sclk_oe,
	output logic             dout_rdy_n,
	output logic             dout_oe,
	output logic             pll_locked
);

	logic         cs_n_s;
	logic         mode_s;
	logic         chsel_s;
	logic         range_s;
	logic         sclk_s;
	logic [23:0]  pair1_s;
	logic [23:0]  pair2_s;

	pin_sync #(.WIDTH(53)) u_sync (
		.clk   (clk),
		.rst   (rst),
		.pin   ({cs_n, mode_slave, input_pair_select, range_wide, sclk_in,
		         input_pair1_pos, input_pair2_pos}),
		.level ({cs_n_s, mode_s, chsel_s, range_s, sclk_s, pair1_s, pair2_s})
	);

	logic active;
	assign active = !cs_n_s;

	// crystal timebase: half-period enable and full-period tick
	logic [15:0] half_cnt_q;
	logic        half_tick_q;
	logic        phase_q;
	logic        xtal_tick;

	always_ff @(posedge clk)
	begin
		if (rst || !active)
		begin
			half_cnt_q  <= '0;
			half_tick_q <= 1'b0;
			phase_q     <= 1'b0;
		end
		else if (half_cnt_q == 16'(HALF_CYCLES - 1))
		begin
			half_cnt_q  <= '0;
			half_tick_q <= 1'b1;
			phase_q     <= !phase_q;
		end
		else
		begin
			half_cnt_q  <= half_cnt_q + 16'h0001;
			half_tick_q <= 1'b0;
		end
	end

	// the modulator and converter advance once per crystal period
	assign xtal_tick = half_tick_q && phase_q;

	// power state: standby, lock wait, running
	power_state_t pw_q;
	logic [15:0]  lock_cnt_q;
	logic         run;

	always_ff @(posedge clk)
	begin
		if (rst || !active)
		begin
			pw_q       <= PW_STANDBY;
			lock_cnt_q <= '0;
		end
		else
		begin
			case (pw_q)
				PW_STANDBY:
				begin
					pw_q       <= PW_LOCK;
					lock_cnt_q <= '0;
				end
				PW_LOCK:
				begin
					if (xtal_tick)
					begin
						if (lock_cnt_q == 16'(LOCK_PERIOD - 1))
							pw_q <= PW_RUN;
						else
							lock_cnt_q <= lock_cnt_q + 16'h0001;
					end
				end
				PW_RUN:
					pw_q <= PW_RUN;
				default:
					pw_q <= PW_STANDBY;
			endcase
		end
	end

	assign run = (pw_q == PW_RUN);

	// input scaling to offset binary with saturation
	function automatic logic [23:0] to_code(input logic [23:0] ain, input logic wide);
		logic signed [29:0] scaled;
		logic signed [29:0] sum;
		scaled = 30'(signed'(ain));
		if (!wide)
			scaled = scaled <<< GAIN_HI_SHIFT;
		sum = scaled + signed'(30'(CODE_ZERO));
		if (sum < 0)
			to_code = CODE_MIN;
		else if (sum > signed'(30'(CODE_MAX)))
			to_code = CODE_MAX;
		else
			to_code = sum[23:0];
	endfunction

	// conversion sequencing
	logic [15:0]  conv_cnt_q;
	logic [1:0]   settle_q;
	logic         chsel_last_q;
	logic [23:0]  sample_q;
	logic [23:0]  push_data_q;
	logic         push_valid_q;
	logic         fifo_in_ready;
	logic         conv_end;
	logic         near_update;

	assign conv_end    = run && xtal_tick && (conv_cnt_q == 16'(CONV_PERIOD - 1));
	assign near_update = run && xtal_tick && (conv_cnt_q == 16'(CONV_PERIOD - 2))
	                     && (settle_q == 2'b00);

	always_ff @(posedge clk)
	begin
		if (rst || !run)
		begin
			conv_cnt_q   <= '0;
			settle_q     <= '0;
			chsel_last_q <= chsel_s;
			sample_q     <= CODE_ZERO;
		end
		else if (chsel_s != chsel_last_q)
		begin
			// restart and drop the first word so two periods pass
			chsel_last_q <= chsel_s;
			conv_cnt_q   <= '0;
			settle_q     <= 2'(SETTLE_CONV - 1);
		end
		else if (xtal_tick)
		begin
			sample_q <= to_code(chsel_s ? pair2_s : pair1_s, range_s);
			if (conv_end)
			begin
				conv_cnt_q <= '0;
				if (settle_q != 2'b00)
					settle_q <= settle_q - 2'b01;
			end
			else
				conv_cnt_q <= conv_cnt_q + 16'h0001;
		end
	end

	// result handed to the buffer; held while the buffer is full
	always_ff @(posedge clk)
	begin
		if (rst || !run)
		begin
			push_valid_q <= 1'b0;
			push_data_q  <= CODE_ZERO;
		end
		else if (conv_end && settle_q == 2'b00 && chsel_s == chsel_last_q)
		begin
			push_valid_q <= 1'b1;
			push_data_q  <= sample_q;
		end
		else if (fifo_in_ready)
			push_valid_q <= 1'b0;
	end

	logic        fifo_out_valid;
	logic [23:0] fifo_out_data;
	logic        fifo_pop_q;

	result_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk       (clk),
		.rst       (rst),
		.flush     (!run),
		.in_valid  (push_valid_q),
		.in_ready  (fifo_in_ready),
		.in_data   (push_data_q),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop_q),
		.out_data  (fifo_out_data)
	);

	// serial clock events in the active mode
	logic sclk_d_q;
	logic fall_evt;
	logic rise_evt;

	always_ff @(posedge clk)
	begin
		if (rst)
			sclk_d_q <= 1'b1;
		else
			sclk_d_q <= sclk_s;
	end

	always_comb
	begin
		if (mode_s)
		begin
			fall_evt = sclk_d_q && !sclk_s;
			rise_evt = !sclk_d_q && sclk_s;
		end
		else
		begin
			fall_evt = half_tick_q && sclk_out;
			rise_evt = half_tick_q && !sclk_out;
		end
	end

	// readout sequencer
	read_state_t  rd_q;
	logic [23:0]  shreg_q;
	logic [4:0]   bit_cnt_q;
	logic         wait_q;

	always_ff @(posedge clk)
	begin
		if (rst || !run)
		begin
			rd_q       <= RD_IDLE;
			shreg_q    <= '0;
			bit_cnt_q  <= '0;
			wait_q     <= 1'b0;
			fifo_pop_q <= 1'b0;
			dout_rdy_n <= 1'b1;
			sclk_out   <= 1'b1;
		end
		else
		begin
			fifo_pop_q <= 1'b0;
			case (rd_q)
				RD_IDLE:
				begin
					dout_rdy_n <= 1'b1;
					sclk_out   <= 1'b1;
					bit_cnt_q  <= '0;
					wait_q     <= 1'b0;
					if (fifo_out_valid && !fifo_pop_q)
					begin
						shreg_q    <= fifo_out_data;
						fifo_pop_q <= 1'b1;
						dout_rdy_n <= 1'b0;
						rd_q       <= RD_READY;
					end
				end
				RD_READY:
				begin
					if (near_update)
					begin
						dout_rdy_n <= 1'b1;
						rd_q       <= RD_IDLE;
					end
					else if (!mode_s)
					begin
						// two half ticks guarantee a full half period low
						if (half_tick_q)
						begin
							if (wait_q)
								rd_q <= RD_SHIFT;
							wait_q <= 1'b1;
						end
					end
					else if (fall_evt)
					begin
						dout_rdy_n <= shreg_q[WORD_BITS-1];
						shreg_q    <= {shreg_q[WORD_BITS-2:0], 1'b0};
						bit_cnt_q  <= 5'd1;
						rd_q       <= RD_SHIFT;
					end
				end
				RD_SHIFT:
				begin
					// pauses simply wait here with the count intact
					if (fall_evt && bit_cnt_q != 5'(WORD_BITS))
					begin
						if (!mode_s)
							sclk_out <= 1'b0;
						dout_rdy_n <= shreg_q[WORD_BITS-1];
						shreg_q    <= {shreg_q[WORD_BITS-2:0], 1'b0};
						bit_cnt_q  <= bit_cnt_q + 5'd1;
					end
					else if (rise_evt)
					begin
						if (!mode_s)
							sclk_out <= 1'b1;
						if (bit_cnt_q == 5'(WORD_BITS))
						begin
							dout_rdy_n <= 1'b1;
							rd_q       <= RD_DONE;
						end
					end
				end
				RD_DONE:
				begin
					dout_rdy_n <= 1'b1;
					sclk_out   <= 1'b1;
					if (mode_s || half_tick_q)
						rd_q <= RD_IDLE;
				end
				default:
					rd_q <= RD_IDLE;
			endcase
		end
	end

	// pin drivers float whenever chip select is high
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			dout_oe    <= 1'b0;
			sclk_oe    <= 1'b0;
			pll_locked <= 1'b0;
		end
		else
		begin
			dout_oe    <= active;
			sclk_oe    <= active && !mode_s;
			pll_locked <= run;
		end
	end

endmodule

//--- sim/adc_readout_checker.sv
// Purpose: concurrent checks on the readout pins
// Assumes: mode changes only while deselected
// Notes:   bound to the top module
`timescale 1ns/1ps
module adc_readout_checker #(
	parameter int HALF_CYCLES = 305,
	parameter int CONV_PERIOD = 1656,
	parameter int LOCK_PERIOD = 64
) (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        cs_n,
	input wire logic        mode_slave,
	input wire logic        input_pair_select,
	input wire logic        range_wide,
	input wire logic        sclk_in,
	input wire logic [23:0] input_pair1_pos,
	input wire logic [23:0] input_pair2_pos,
	input wire logic        sclk_out,
	input wire logic        sclk_oe,
	input wire logic        dout_rdy_n,
	input wire logic        dout_oe,
	input wire logic        pll_locked
);
	logic [4:0]  rise_q;
	logic [15:0] low_q;
	logic [15:0] rdy_q;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// rising serial clock edges within the current word
	always_ff @(posedge clk)
	begin
		if (rst || !sclk_oe)
			rise_q <= 5'h00;
		else if ($rose(sclk_out))
			rise_q <= (rise_q == 5'h17) ? 5'h00 : rise_q + 5'h01;
	end
	always_ff @(posedge clk)
		low_q <= sclk_out ? 16'h0000 : low_q + 16'h0001;
	always_ff @(posedge clk)
		rdy_q <= dout_rdy_n ? 16'h0000 : rdy_q + 16'h0001;
	sequence s_idle_tail;
		(dout_rdy_n && sclk_out) [*8];
	endsequence
	sequence s_last_rise;
		$rose(sclk_out) && sclk_oe && rise_q == 5'h17;
	endsequence
	property p_oe_off;
		$rose(cs_n) |-> ##[1:5] (!dout_oe && !sclk_oe);
	endproperty
	property p_standby;
		!dout_oe && !$past(dout_oe, 2) |-> dout_rdy_n && !pll_locked;
	endproperty
	property p_lock_wait;
		$rose(dout_oe) |-> !pll_locked [*8];
	endproperty
	property p_sclk_mode;
		sclk_oe |-> !mode_slave && dout_oe;
	endproperty
	property p_half_period;
		$rose(sclk_out) && sclk_oe |-> low_q == 16'(HALF_CYCLES);
	endproperty
	property p_word_end;
		s_last_rise |-> s_idle_tail;
	endproperty
	property p_bit_change;
		sclk_oe && rise_q != 5'h00 && $changed(dout_rdy_n) && !$rose(sclk_out)
			|-> $fell(sclk_out);
	endproperty
	property p_first_edge;
		$fell(sclk_out) && sclk_oe && rise_q == 5'h00 |-> rdy_q >= 16'(HALF_CYCLES);
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("outputs not released");
	a_standby: assert property (p_standby) else $error("standby not idle");
	a_lock_wait: assert property (p_lock_wait) else $error("no lock wait");
	a_sclk_mode: assert property (p_sclk_mode) else $error("clock drive wrong");
	a_half_period: assert property (p_half_period) else $error("half period");
	a_word_end: assert property (p_word_end) else $error("word end idle");
	a_bit_change: assert property (p_bit_change) else $error("bit change edge");
	a_first_edge: assert property (p_first_edge) else $error("ready too short");
endmodule
bind adc_serial_readout adc_readout_checker #(
	.HALF_CYCLES(HALF_CYCLES),
	.CONV_PERIOD(CONV_PERIOD),
	.LOCK_PERIOD(LOCK_PERIOD)
) chk (
	.clk(clk), .rst(rst), .cs_n(cs_n), .mode_slave(mode_slave),
	.input_pair_select(input_pair_select), .range_wide(range_wide), .sclk_in(sclk_in),
	.input_pair1_pos(input_pair1_pos), .input_pair2_pos(input_pair2_pos),
	.sclk_out(sclk_out), .sclk_oe(sclk_oe), .dout_rdy_n(dout_rdy_n),
	.dout_oe(dout_oe), .pll_locked(pll_locked)
);

//--- sim/serial_host.sv
// Purpose: host that reads result words from the serial pins
// Assumes: slave clock of 400 ns period, three groups of eight
// Notes:   samples the data line on rising serial clock
`timescale 1ns/1ps
module serial_host (
	input  wire logic   slave_en,
	input  wire logic   sel,
	input  wire logic   sclk_w,
	input  wire logic   dout_w,
	output logic        sclk_in,
	output logic [23:0] word,
	output logic [7:0]  words
);
	logic [23:0] sh_q;
	logic        dout_late;
	int          cnt;
	initial
	begin
		word = 24'h000000;
		words = 8'h00;
		cnt = 0;
	end
	// delayed copy avoids a race with the edge that moves the data
	always @(dout_w)
		dout_late <= #10 dout_w;
	always @(posedge sclk_w)
	begin
		if (sel)
		begin
			sh_q = {sh_q[22:0], dout_late};
			cnt++;
			if (cnt == 24)
			begin
				word = sh_q;
				words++;
				cnt = 0;
			end
		end
	end
	always @(negedge sel)
		cnt = 0;
	initial
	begin
		sclk_in = 1'b1;
		forever
		begin
			wait (slave_en && sel && !dout_w);
			// keep the clock edges off the sampling edge of the block
			#10;
			repeat (3)
			begin
				repeat (8)
				begin
					#200 sclk_in = 1'b0;
					#200 sclk_in = 1'b1;
				end
				#1000;
			end
		end
	end
endmodule

//--- sim/adc_serial_readout_tb.sv
// Purpose: directed test of the serial readout block
// Assumes: short counts set through the parameters
// Notes:   host model reads every word in both modes
`timescale 1ns/1ps
module adc_serial_readout_tb;
	logic        clk;
	logic        rst;
	logic        cs_n;
	logic        mode_slave;
	logic        input_pair_select;
	logic        range_wide;
	logic [23:0] input_pair1_pos;
	logic [23:0] input_pair2_pos;
	logic        sclk_in;
	logic        sclk_out;
	logic        sclk_oe;
	logic        dout_rdy_n;
	logic        dout_oe;
	logic        pll_locked;
	logic [23:0] word;
	logic [7:0]  words;
	int          num_errors = 0;
	int          n_checks = 0;
	int          cyc = 0;
	wire         sclk_w = sclk_oe ? sclk_out : sclk_in;
	// data line has a pull-up
	wire         dout_w = dout_oe ? dout_rdy_n : 1'b1;
	adc_serial_readout #(.HALF_CYCLES(4), .CONV_PERIOD(200), .LOCK_PERIOD(2)) dut (
		.clk(clk), .rst(rst), .cs_n(cs_n), .mode_slave(mode_slave),
		.input_pair_select(input_pair_select), .range_wide(range_wide), .sclk_in(sclk_in),
		.input_pair1_pos(input_pair1_pos), .input_pair2_pos(input_pair2_pos),
		.sclk_out(sclk_out), .sclk_oe(sclk_oe), .dout_rdy_n(dout_rdy_n),
		.dout_oe(dout_oe), .pll_locked(pll_locked)
	);
	serial_host host (.slave_en(mode_slave), .sel(dout_oe), .sclk_w(sclk_w),
		.dout_w(dout_w), .sclk_in(sclk_in), .word(word), .words(words));
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic wait_word(input logic [23:0] exp, output int k);
		logic [7:0] w0;
		w0 = words;
		k = 0;
		while (words == w0 && k < 4000)
		begin
			@(posedge clk);
			k++;
		end
		check(24'(words != w0), 24'h000001);
		check(word, exp);
	endtask
	task automatic run_case(input logic m, input logic c, input logic r,
		input logic [23:0] v1, input logic [23:0] v2, input logic [23:0] exp,
		input logic [23:0] exp2);
		int k;
		mode_slave <= m;
		input_pair_select <= c;
		range_wide <= r;
		input_pair1_pos <= v1;
		input_pair2_pos <= v2;
		repeat (4) @(posedge clk);
		cs_n <= 1'b0;
		wait_word(exp, k);
		wait_word(exp, k);
		check(24'(k > 1590 && k < 1610), 24'h000001);
		check(24'(sclk_oe), 24'(!m));
		check(24'(dout_oe), 24'h000001);
		check(24'(pll_locked), 24'h000001);
		// switching the pair drops one word, so two periods pass
		input_pair_select <= !c;
		wait_word(exp2, k);
		check(24'(k > 3200 && k < 3700), 24'h000001);
		cs_n <= 1'b1;
		repeat (6) @(posedge clk);
		check(24'({sclk_oe, dout_oe, pll_locked}), 24'h000000);
		repeat (20) @(posedge clk);
	endtask
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 60000)
		begin
			num_errors++;
			print_verdict();
		end
	end
	initial
	begin
		rst = 1'b1;
		cs_n = 1'b1;
		mode_slave = 1'b0;
		input_pair_select = 1'b0;
		range_wide = 1'b1;
		input_pair1_pos = 24'h000000;
		input_pair2_pos = 24'h000000;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		run_case(1'b0, 1'b0, 1'b1, 24'h000100, 24'h0000aa, 24'h800100, 24'h8000aa);
		run_case(1'b0, 1'b0, 1'b0, 24'h000010, 24'h0000aa, 24'h800100, 24'h800aa0);
		run_case(1'b0, 1'b1, 1'b1, 24'h0000aa, 24'hffff00, 24'h7fff00, 24'h8000aa);
		run_case(1'b1, 1'b0, 1'b1, 24'h7fffff, 24'h000000, 24'hffffff, 24'h800000);
		run_case(1'b1, 1'b1, 1'b0, 24'h0000aa, 24'h800000, 24'h000000, 24'h800aa0);
		run_case(1'b1, 1'b0, 1'b0, 24'h000000, 24'h0000aa, 24'h800000, 24'h800aa0);
		print_verdict();
	end
endmodule
